// ---- dv/ext_bus_ready_waitstate_ctrl_tb.sv ----
// Purpose: Self-checking bench for the ready wait-state controller
// Assumes: Inputs change on falling edges; WAIT_LIMIT shortened
// Notes:   Access length counted in clocks from the start edge
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ready_waitstate_ctrl_tb;
   // ****************************************
   // Clock, reset, instances
   // ****************************************
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              start = 1'b0;
   rwc_pkg::rwc_cfg_t cfg = '0;
   logic              hi = 1'b1;
   logic [7:0]        dly = 8'hFF;
   logic              rdy, strobe_n, busy, done, wst, tmo;
   int                fails = 0;
   int                n_compared = 0;
   int                cyc, w;
   always #20 clk = ~clk;
   rwc_ctrl #(.WAIT_LIMIT(16'h0010)) DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_start(start),
      .i_cfg(cfg), .i_rdy_pin(rdy), .o_strobe_n(strobe_n), .o_busy(busy), .o_done(done),
      .o_wait_state(wst), .o_timeout(tmo));
   rwc_rdy_model PEER (.i_ref_clk(clk), .i_strobe_n(strobe_n), .i_high_act(hi),
      .i_dly(dly), .o_rdy_pin(rdy));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Bounded wait, so a stuck cycle shows as a wrong length
   task automatic run(input logic [5:0] acc, input logic asy, input logic h,
                      input logic en, input logic [7:0] d);
      cfg = '{rdy_high_act: h, rdy_async: asy, rdy_en: en, acc_len: acc};
      hi = h;
      dly = d;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      check({15'h0000, busy}, 16'h0001);
      check({15'h0000, strobe_n}, 16'h0000);
      cyc = 0;
      w = 0;
      while (done !== 1'b1 && cyc < 300) begin
         @(negedge clk);
         cyc++;
         if (wst === 1'b1) begin
            w++;
         end
      end
      check({15'h0000, done}, 16'h0001);
      check({15'h0000, strobe_n}, 16'h0001);
      check({15'h0000, busy}, 16'h0000);
      @(negedge clk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_prompt();
      for (int p = 0; p < 2; p++) begin
         run(6'h06, 1'b0, p[0], 1'b1, 8'h00);
         check(16'(cyc), 16'h0008);
         check(16'(w), 16'h0000);
         run(6'h06, 1'b1, p[0], 1'b1, 8'h00);
         check(16'(w), 16'h0001);
         check(16'(cyc), 16'h0009);
      end
   endtask
   task automatic t_slow();
      int ws;
      run(6'h03, 1'b0, 1'b1, 1'b1, 8'h0A);
      ws = w;
      check(16'(w), 16'h000A);
      check(16'(cyc), 16'h000F);
      run(6'h03, 1'b1, 1'b0, 1'b1, 8'h0A);
      check(16'(w), 16'(ws + 1));
      check(16'(cyc), 16'h0010);
   endtask
   task automatic t_fixed();
      run(6'h01, 1'b0, 1'b1, 1'b0, 8'hFF);
      check(16'(cyc), 16'h0002);
      run(6'h20, 1'b1, 1'b1, 1'b0, 8'hFF);
      check(16'(cyc), 16'h0021);
   endtask
   // Silent partner: the guard limit must end the cycle
   task automatic t_tmo();
      run(6'h01, 1'b0, 1'b1, 1'b1, 8'hFF);
      check(16'(cyc), 16'h0013);
      check(16'(w), 16'h0010);
      check({15'h0000, tmo}, 16'h0001);
      run(6'h01, 1'b0, 1'b1, 1'b0, 8'hFF);
      check({15'h0000, tmo}, 16'h0000);
      check(16'(cyc), 16'h0002);
   endtask
   task automatic t_reset();
      cfg = '{rdy_high_act: 1'b1, rdy_async: 1'b0, rdy_en: 1'b1, acc_len: 6'h04};
      hi = 1'b1;
      dly = 8'hFF;
      start = 1'b1;
      @(negedge clk);
      check({15'h0000, busy}, 16'h0001);
      // Start left high while busy; the new length must not be taken
      cfg.acc_len = 6'h01;
      repeat (5) @(negedge clk);
      check({15'h0000, wst}, 16'h0001);
      check({15'h0000, strobe_n}, 16'h0000);
      start = 1'b0;
      nrst = 1'b0;
      @(negedge clk);
      check({12'h000, strobe_n, busy, wst, tmo}, 16'h0008);
      check({15'h0000, done}, 16'h0000);
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      run(6'h03, 1'b0, 1'b1, 1'b1, 8'h00);
      check(16'(cyc), 16'h0005);
      check(16'(w), 16'h0000);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      t_prompt();
      t_slow();
      t_fixed();
      t_tmo();
      t_reset();
      print_verdict();
   end
   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- dv/rwc_rdy_model.sv ----
// Purpose: Far-side peripheral model that drives the ready pin
// Assumes: Ready changes just after rising edges of i_ref_clk
// Notes:   An i_dly of 8'hFF keeps ready inactive for the whole access
`timescale 1ns/1ps
`default_nettype none
module rwc_rdy_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_strobe_n,
   input  wire logic       i_high_act,
   input  wire logic [7:0] i_dly,
   output logic            o_rdy_pin
);
   // ****************************************
   // Ready generation
   // ****************************************
   logic [7:0] cnt_r = 8'h00;
   logic       act_r = 1'b0;
   // Level held for whole clocks, so async capture is safe
   always @(posedge i_ref_clk) begin
      if (i_strobe_n) begin
         cnt_r <= 8'h00;
         act_r <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         act_r <= (i_dly != 8'hFF) && (cnt_r >= i_dly);
      end
   end
   assign o_rdy_pin = act_r ? i_high_act : ~i_high_act;
endmodule
`default_nettype wire

// ---- rtl/rwc_ctrl.sv ----
// Purpose: Access-phase wait-state control driven by the ready handshake
// Assumes: Bus sequencer raises i_start for one cycle per access
// Notes:   No software registers; configuration arrives as a struct
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Ready polarity is selectable high-active or low-active.
// - Synchronous mode uses ready with minimal delay; partner syncs to bus clock.
// - Asynchronous mode adds a sync stage, costing at least one waitstate.
// - First sampling point follows the programmed access phase length.
// - Inactive ready at a sample inserts one waitstate, then resamples.
// - Active ready at a sample ends the access phase.
// - Async sampling point lies later than synchronous one.
// - Ready may extend access beyond mandatory waitstates.
module rwc_ctrl #(
   parameter logic [15:0] WAIT_LIMIT = rwc_pkg::WAIT_LIMIT_RST
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_start,
   input  wire rwc_pkg::rwc_cfg_t i_cfg,
   input  wire logic              i_rdy_pin,
   output logic                   o_strobe_n,
   output logic                   o_busy,
   output logic                   o_done,
   output logic                   o_wait_state,
   output logic                   o_timeout
);
   rwc_pkg::rwc_state_t st_r;
   rwc_pkg::rwc_state_t st_nxt;
   rwc_pkg::rwc_cfg_t   cfg_r;
   rwc_pkg::rwc_cfg_t   cfg_nxt;
   logic [5:0]          cnt_r;
   logic [5:0]          cnt_nxt;
   logic [15:0]         wcnt_r;
   logic [15:0]         wcnt_nxt;
   logic                strobe_n_r;
   logic                strobe_n_nxt;
   logic                done_r;
   logic                done_nxt;
   logic                wait_r;
   logic                wait_nxt;
   logic                tmo_r;
   logic                tmo_nxt;
   logic                rdy_sync;
   logic                rdy_async;
   logic                rdy_sel;
   logic                skip_r;
   logic                skip_nxt;
   logic                busy_r;
   logic                busy_nxt;

   rwc_rdy_sync u_sync (
      .i_ref_clk  (i_ref_clk),
      .i_nrst     (i_nrst),
      .i_rdy_pin  (i_rdy_pin),
      .i_high_act (cfg_r.rdy_high_act),
      .o_rdy_sync (rdy_sync),
      .o_rdy_async(rdy_async)
   );

   // Mode picks the tap; async tap lags one state behind
   assign rdy_sel = cfg_r.rdy_async ? rdy_async : rdy_sync;

   function automatic logic [5:0] clamp_len(input logic [5:0] len);
      if (len < rwc_pkg::ACC_LEN_MIN) begin
         clamp_len = rwc_pkg::ACC_LEN_MIN;
      end else if (len > rwc_pkg::ACC_LEN_MAX) begin
         clamp_len = rwc_pkg::ACC_LEN_MAX;
      end else begin
         clamp_len = len;
      end
   endfunction

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      st_nxt       = st_r;
      cfg_nxt      = cfg_r;
      cnt_nxt      = cnt_r;
      wcnt_nxt     = wcnt_r;
      strobe_n_nxt = strobe_n_r;
      done_nxt     = 1'b0;
      wait_nxt     = 1'b0;
      tmo_nxt      = tmo_r;
      skip_nxt     = skip_r;
      unique case (st_r)
         rwc_pkg::ST_IDLE: begin
            if (i_start) begin
               cfg_nxt         = i_cfg;
               cfg_nxt.acc_len = clamp_len(i_cfg.acc_len);
               cnt_nxt         = clamp_len(i_cfg.acc_len) - 6'h01;
               wcnt_nxt        = 16'h0000;
               strobe_n_nxt    = 1'b0;
               tmo_nxt         = 1'b0;
               skip_nxt        = i_cfg.rdy_async;
               st_nxt          = rwc_pkg::ST_ACC;
            end
         end
         rwc_pkg::ST_ACC: begin
            // Mandatory waitstates; ready is not looked at here
            if (cnt_r != 6'h00) begin
               cnt_nxt = cnt_r - 6'h01;
            end else if (!cfg_r.rdy_en) begin
               st_nxt = rwc_pkg::ST_END;
            end else begin
               st_nxt = rwc_pkg::ST_WAIT;
            end
         end
         rwc_pkg::ST_WAIT: begin
            wcnt_nxt = wcnt_r + 16'h0001;
            if (skip_r) begin
               // Async: first sample slot lost to the extra stage
               skip_nxt = 1'b0;
               wait_nxt = 1'b1;
            end else if (rdy_sel) begin
               st_nxt = rwc_pkg::ST_END;
            end else if (wcnt_r == WAIT_LIMIT) begin
               // Guard against a partner that never answers
               tmo_nxt = 1'b1;
               st_nxt  = rwc_pkg::ST_END;
            end else begin
               wait_nxt = 1'b1;
            end
         end
         rwc_pkg::ST_END: begin
            strobe_n_nxt = 1'b1;
            done_nxt     = 1'b1;
            st_nxt       = rwc_pkg::ST_IDLE;
         end
         default: begin
            st_nxt = rwc_pkg::ST_IDLE;
         end
      endcase
      // Registered so the busy pin carries no decode glitch
      busy_nxt = (st_nxt != rwc_pkg::ST_IDLE);
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         st_r       <= rwc_pkg::ST_IDLE;
         cfg_r      <= '0;
         cnt_r      <= 6'h00;
         wcnt_r     <= 16'h0000;
         strobe_n_r <= 1'b1;
         done_r     <= 1'b0;
         wait_r     <= 1'b0;
         tmo_r      <= 1'b0;
         skip_r     <= 1'b0;
         busy_r     <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         cfg_r      <= cfg_nxt;
         cnt_r      <= cnt_nxt;
         wcnt_r     <= wcnt_nxt;
         strobe_n_r <= strobe_n_nxt;
         done_r     <= done_nxt;
         wait_r     <= wait_nxt;
         tmo_r      <= tmo_nxt;
         skip_r     <= skip_nxt;
         busy_r     <= busy_nxt;
      end
   end

   assign o_strobe_n   = strobe_n_r;
   assign o_busy       = busy_r;
   assign o_done       = done_r;
   assign o_wait_state = wait_r;
   assign o_timeout    = tmo_r;

   // ****************************************
   // Checks
   // ****************************************
   AST_NO_RDY_IN_ACC: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_ACC) && (cnt_r != 6'h00)
      |=> (st_r == rwc_pkg::ST_ACC) && !o_wait_state && !o_done)
      else $error("ready acted during mandatory waitstates");
   AST_RDY_ENDS: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_WAIT) && !skip_r && rdy_sel |=> (st_r == rwc_pkg::ST_END)
      ##1 (o_strobe_n && o_done))
      else $error("active ready did not end cycle");
   AST_NOT_RDY_WAITS: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_WAIT) && !rdy_sel && (wcnt_r != WAIT_LIMIT)
      |=> o_wait_state && (st_r == rwc_pkg::ST_WAIT))
      else $error("inactive ready did not insert waitstate");
   AST_ASYNC_SKIP: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_WAIT) && skip_r |=> o_wait_state && !o_done)
      else $error("async mode missed its extra waitstate");
   AST_ACC_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_IDLE) && i_start && (i_cfg.acc_len == 6'h03)
      |=> (st_r == rwc_pkg::ST_ACC) [*3] ##1 (st_r != rwc_pkg::ST_ACC))
      else $error("access phase length wrong");
   AST_ASYNC_LATER: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(st_r == rwc_pkg::ST_WAIT) && cfg_r.rdy_async |-> ##1 (st_r == rwc_pkg::ST_WAIT))
      else $error("async sample not later");
   AST_ASYNC_TAP: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r != rwc_pkg::ST_IDLE) && $stable(cfg_r) |-> (rdy_async == $past(rdy_sync)))
      else $error("async tap does not trail sync tap by one state");
   AST_NO_RDY_EXT: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_ACC) && (cnt_r == 6'h00) && !cfg_r.rdy_en
      |=> (st_r == rwc_pkg::ST_END))
      else $error("cycle extended without ready enabled");
   AST_POLARITY: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r != rwc_pkg::ST_IDLE)
      |-> (rdy_sync == ($past(i_rdy_pin, 2) == cfg_r.rdy_high_act)))
      else $error("polarity not applied");
   AST_TMO: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r == rwc_pkg::ST_WAIT) && !skip_r && !rdy_sel && (wcnt_r == WAIT_LIMIT)
      |=> o_timeout && !o_wait_state && (st_r == rwc_pkg::ST_END))
      else $error("silent partner did not end the cycle");
   AST_DONE_STROBE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_strobe_n) |-> o_done)
      else $error("strobe rose without done");
   AST_START_IGNORED: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (st_r != rwc_pkg::ST_IDLE) && i_start |=> $stable(cfg_r))
      else $error("start taken while busy");
endmodule
`default_nettype wire

// ---- rtl/rwc_rdy_sync.sv ----
// Purpose: Ready pin conditioning: two-stage sync, extra async stage, polarity
// Assumes: Ready pin is asynchronous to i_ref_clk at board level
// Notes:   Outputs are combinational polarity compares of registered stages
`timescale 1ns/1ps
`default_nettype none
module rwc_rdy_sync (
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   input  wire logic i_rdy_pin,
   input  wire logic i_high_act,
   output logic      o_rdy_sync,
   output logic      o_rdy_async
);
   logic meta_r;
   logic meta_nxt;
   logic s2_r;
   logic s2_nxt;
   logic s3_r;
   logic s3_nxt;

   // ****************************************
   // Sampling
   // ****************************************
   always_comb begin
      meta_nxt = i_rdy_pin;
      s2_nxt   = meta_r;
      s3_nxt   = s2_r;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         meta_r <= 1'b0;
         s2_r   <= 1'b0;
         s3_r   <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         s2_r   <= s2_nxt;
         s3_r   <= s3_nxt;
      end
   end

   // Polarity applied after sync; meta stage stays untouched
   assign o_rdy_sync  = (s2_r == i_high_act);
   assign o_rdy_async = (s3_r == i_high_act);
endmodule
`default_nettype wire

// ---- shared/rwc_pkg.sv ----
// Purpose: Shared constants and types for the ready wait-state controller
// Assumes: One clock at 25 MHz; no software registers
// Notes:   Phase lengths count in bus clock states
`default_nettype none
package rwc_pkg;
   // ****************************************
   // Phase limits
   // ****************************************
   localparam int unsigned ACC_LEN_W     = 6;
   localparam logic [5:0]  ACC_LEN_MIN   = 6'h01;
   localparam logic [5:0]  ACC_LEN_MAX   = 6'h20;
   localparam logic [5:0]  ACC_LEN_RST   = 6'h01;
   localparam int unsigned WAIT_CNT_W    = 16;
   localparam logic [15:0] WAIT_LIMIT_RST = 16'hFFFF;
   // Asynchronous sampling point trails the synchronous one by this many states
   localparam logic [1:0]  ASYNC_EXTRA   = 2'h1;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       rdy_high_act;
      logic       rdy_async;
      logic       rdy_en;
      logic [5:0] acc_len;
   } rwc_cfg_t;

   typedef struct packed {
      logic       busy;
      logic       strobe;
      logic       done;
      logic       timeout;
   } rwc_stat_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ACC  = 4'h2,
      ST_WAIT = 4'h4,
      ST_END  = 4'h8
   } rwc_state_t;
endpackage
`default_nettype wire
